// file: ocr_pkg.sv
// Package with register map, reset values and carrier types for offset regs.
package ocr_pkg;

	// Register bytes are 8 bits; only the low six bits hold a value (the low three in the gain-mode register).
	localparam int          OCR_DATA_W         = 8;
	localparam int          OCR_ADDR_W         = 8;
	localparam int          OCR_FIELD_W        = 6;
	localparam int          OCR_MAG_W          = 5;
	localparam int          OCR_SIGN_BIT       = 5;
	localparam int          OCR_COL_W          = 11;
	localparam int          OCR_NUM_COL_REGS   = 64;
	localparam int          OCR_COL_SEL_W      = 6;

	// Register offsets.
	localparam logic [7:0]  OCR_ADDR_COL_DC    = 8'h20;
	localparam logic [7:0]  OCR_ADDR_GAIN_MODE = 8'h22;
	localparam logic [7:0]  OCR_ADDR_GLOBAL    = 8'h23;
	localparam logic [7:0]  OCR_ADDR_COL_BASE  = 8'h80;
	localparam logic [7:0]  OCR_ADDR_COL_LAST  = 8'hBF;

	// Values after reset.
	localparam logic [5:0]  OCR_RST_COL_DC     = 6'h00;
	localparam logic [2:0]  OCR_RST_GAIN_MODE  = 3'h0;
	localparam logic [5:0]  OCR_RST_GLOBAL     = 6'h00;
	localparam logic [5:0]  OCR_RST_COL_OFS    = 6'h00;

	// Gain-mode register field positions.
	localparam int          OCR_GM_WBM_BIT     = 2;
	localparam int          OCR_GM_EGM_LSB     = 0;
	localparam int          OCR_GM_W           = 3;

	// Each global offset step moves the converted output by four codes.
	localparam int          OCR_GLOBAL_SHIFT   = 2;
	localparam int          OCR_GLOBAL_CODE_W  = 8;
	localparam int          OCR_COMB_W         = 7;

	typedef enum logic [1:0] {
		OCR_EGM_RAW     = 2'h0,
		OCR_EGM_LINEAR  = 2'h1,
		OCR_EGM_LINEAR2 = 2'h2,
		OCR_EGM_RSVD    = 2'h3
	} ocr_egm_t;

	// Register access from the serial configuration engine.
	typedef struct packed {
		logic                  wr;
		logic                  rd;
		logic [OCR_ADDR_W-1:0] addr;
		logic [OCR_DATA_W-1:0] data;
	} ocr_reg_req_t;

	// Column position of the pixel entering the early offset stage.
	typedef struct packed {
		logic                 valid;
		logic [OCR_COL_W-1:0] index;
	} ocr_col_t;

	// Gain-mode selection for the amplifier stage.
	typedef struct packed {
		logic     wb_linear;
		ocr_egm_t exp_mode;
		logic     gain_b_used;
	} ocr_gain_cfg_t;

	// Sign-magnitude byte field to two's complement, in register steps.
	function automatic logic signed [OCR_FIELD_W:0] ocr_sm_to_signed(
		input logic [OCR_FIELD_W-1:0] f
	);
		logic signed [OCR_FIELD_W:0] mag;
		mag = $signed({2'b00, f[OCR_MAG_W-1:0]});
		ocr_sm_to_signed = f[OCR_SIGN_BIT] ? -mag : mag;
	endfunction : ocr_sm_to_signed

endpackage : ocr_pkg

// file: ocr_col_offset.sv
// Early column offset stage: per-column table lookup plus column DC offset.
`timescale 1ns/1ps
module ocr_col_offset
	import ocr_pkg::*;
(
	// Clock and reset
	input  wire logic                                     i_clk,
	input  wire logic                                     i_reset_n,
	// Settings
	input  wire logic [OCR_FIELD_W-1:0]                   i_col_dc,
	input  wire logic [OCR_NUM_COL_REGS-1:0][OCR_FIELD_W-1:0] i_col_tab,
	// Column stream
	input  wire ocr_col_t                                 i_col,
	output logic                                          o_valid,
	output logic signed [OCR_COMB_W-1:0]                  o_offset
);

	// Column number modulo 64 is just its low six bits.
	wire logic [OCR_COL_SEL_W-1:0]      sel;
	wire logic [OCR_FIELD_W-1:0]        tab_field;
	wire logic signed [OCR_FIELD_W:0]   dc_s;
	wire logic signed [OCR_FIELD_W:0]   tab_s;
	wire logic signed [OCR_COMB_W-1:0]  sum;

	assign sel       = i_col.index[OCR_COL_SEL_W-1:0];
	assign tab_field = i_col_tab[sel];
	assign dc_s      = ocr_sm_to_signed(i_col_dc);
	assign tab_s     = ocr_sm_to_signed(tab_field);
	// Each term spans -31..31, so the sum fits seven bits without overflow.
	assign sum       = OCR_COMB_W'(dc_s + tab_s);

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_valid  <= 1'b0;
			o_offset <= '0;
		end else begin
			o_valid  <= i_col.valid;
			o_offset <= i_col.valid ? sum : o_offset;
		end
	end

endmodule : ocr_col_offset

// file: ocr_global_offset.sv
// Late global offset stage: sign-magnitude setting to output code shift.
`timescale 1ns/1ps
module ocr_global_offset
	import ocr_pkg::*;
(
	// Clock and reset
	input  wire logic                                i_clk,
	input  wire logic                                i_reset_n,
	// Setting
	input  wire logic [OCR_FIELD_W-1:0]              i_global,
	// Offset ahead of conversion
	output logic signed [OCR_GLOBAL_CODE_W-1:0]      o_code
);

	wire logic signed [OCR_FIELD_W:0]          steps;
	wire logic signed [OCR_GLOBAL_CODE_W-1:0]  code;

	assign steps = ocr_sm_to_signed(i_global);
	// Magnitude 31 times four gives the full plus or minus 124 range.
	assign code  = OCR_GLOBAL_CODE_W'(steps) <<< OCR_GLOBAL_SHIFT;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_code <= '0;
		end else begin
			o_code <= code;
		end
	end

endmodule : ocr_global_offset

// file: ocr_offset_regs.sv
// Offset calibration and gain-mode register bank with its offset stages.
`timescale 1ns/1ps
module ocr_offset_regs
	import ocr_pkg::*;
(
	// Clock and reset
	input  wire logic                           i_clk,
	input  wire logic                           i_reset_n,
	// Register access from the serial configuration engine
	input  wire ocr_reg_req_t                   i_req,
	output logic [OCR_DATA_W-1:0]               o_rd_data,
	output logic                                o_rd_valid,
	output logic                                o_rd_hit,
	// Column stream from the readout timing
	input  wire ocr_col_t                       i_col,
	// Settings to the analog processing chain
	output ocr_gain_cfg_t                       o_gain_cfg,
	output logic                                o_col_offset_valid,
	output logic signed [OCR_COMB_W-1:0]        o_col_offset,
	output logic signed [OCR_GLOBAL_CODE_W-1:0] o_global_offset_value
);

	// Register storage; bits 7 and 6 (bits 7 to 3 of the gain-mode register) are not kept and read back as zero.
	logic [OCR_FIELD_W-1:0]                        col_dc_reg;
	logic [OCR_GM_W-1:0]                           gain_mode_reg;
	logic [OCR_FIELD_W-1:0]                        global_reg;
	logic [OCR_NUM_COL_REGS-1:0][OCR_FIELD_W-1:0]  col_tab_reg;
	logic [OCR_DATA_W-1:0]                         rd_data_reg;
	logic                                          rd_valid_reg;
	logic                                          rd_hit_reg;
	ocr_gain_cfg_t                                 gain_cfg_reg;
	ocr_gain_cfg_t                                 gain_cfg_next;

	// Address decode.
	wire logic                      hit_col_dc;
	wire logic                      hit_gain_mode;
	wire logic                      hit_global;
	wire logic                      hit_col_tab;
	wire logic                      hit_any;
	wire logic [OCR_COL_SEL_W-1:0]  tab_idx;
	wire logic [OCR_DATA_W-1:0]     rd_mux;
	wire logic [1:0]                egm_field;

	assign hit_col_dc    = (i_req.addr == OCR_ADDR_COL_DC);
	assign hit_gain_mode = (i_req.addr == OCR_ADDR_GAIN_MODE);
	assign hit_global    = (i_req.addr == OCR_ADDR_GLOBAL);
	assign hit_col_tab   = (i_req.addr >= OCR_ADDR_COL_BASE) &&
	                       (i_req.addr <= OCR_ADDR_COL_LAST);
	assign hit_any       = hit_col_dc | hit_gain_mode | hit_global |
	                       hit_col_tab;
	assign tab_idx       = OCR_COL_SEL_W'(i_req.addr - OCR_ADDR_COL_BASE);

	// Unmapped addresses read zero so the host sees a stable answer.
	assign rd_mux = hit_col_dc    ? {2'b00, col_dc_reg} :
	                hit_gain_mode ? {5'b00000, gain_mode_reg} :
	                hit_global    ? {2'b00, global_reg} :
	                hit_col_tab   ? {2'b00, col_tab_reg[tab_idx]} :
	                                8'h00;

	// Gain-mode decode; the reserved exposure code behaves as raw.
	assign egm_field = gain_mode_reg[OCR_GM_EGM_LSB +: 2];
	always_comb begin
		gain_cfg_next.wb_linear = gain_mode_reg[OCR_GM_WBM_BIT];
		case (egm_field)
			2'h1:    gain_cfg_next.exp_mode = OCR_EGM_LINEAR;
			2'h2:    gain_cfg_next.exp_mode = OCR_EGM_LINEAR2;
			default: gain_cfg_next.exp_mode = OCR_EGM_RAW;
		endcase
		// Linear-2 drives the amplifier from the first global gain only.
		gain_cfg_next.gain_b_used = (egm_field != 2'h2);
	end

	// Scalar registers.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			col_dc_reg    <= OCR_RST_COL_DC;
			gain_mode_reg <= OCR_RST_GAIN_MODE;
			global_reg    <= OCR_RST_GLOBAL;
		end else if (i_req.wr) begin
			if (hit_col_dc)
				col_dc_reg <= i_req.data[OCR_FIELD_W-1:0];
			if (hit_gain_mode)
				gain_mode_reg <= i_req.data[OCR_GM_W-1:0];
			if (hit_global)
				global_reg <= i_req.data[OCR_FIELD_W-1:0];
		end
	end

	// Per-column table, one entry written per access.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int k = 0; k < OCR_NUM_COL_REGS; k++) begin
				col_tab_reg[k] <= OCR_RST_COL_OFS;
			end
		end else if (i_req.wr && hit_col_tab) begin
			col_tab_reg[tab_idx] <= i_req.data[OCR_FIELD_W-1:0];
		end
	end

	// Read answer one cycle after the request; gain config retimed.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rd_data_reg  <= 8'h00;
			rd_valid_reg <= 1'b0;
			rd_hit_reg   <= 1'b0;
			gain_cfg_reg <= '0;
		end else begin
			rd_valid_reg <= i_req.rd;
			rd_hit_reg   <= i_req.rd & hit_any;
			if (i_req.rd)
				rd_data_reg <= rd_mux;
			gain_cfg_reg <= gain_cfg_next;
		end
	end

	assign o_rd_data  = rd_data_reg;
	assign o_rd_valid = rd_valid_reg;
	assign o_rd_hit   = rd_hit_reg;
	assign o_gain_cfg = gain_cfg_reg;

	// Early stage: the column offset rides with each column strobe.
	ocr_col_offset u_col_offset (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_col_dc  (col_dc_reg),
		.i_col_tab (col_tab_reg),
		.i_col     (i_col),
		.o_valid   (o_col_offset_valid),
		.o_offset  (o_col_offset)
	);

	// Late stage: the global offset is a steady level ahead of the converter.
	ocr_global_offset u_global_offset (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_global  (global_reg),
		.o_code    (o_global_offset_value)
	);

endmodule : ocr_offset_regs

// file: ocr_offset_regs_asserts.sv
// Port-level timing checks on the offset register bank.
`timescale 1ns/1ps
module ocr_offset_regs_asserts
	import ocr_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Register port and column stream
	input wire ocr_reg_req_t i_req,
	input wire ocr_col_t i_col,
	input wire logic [OCR_DATA_W-1:0] o_rd_data,
	input wire logic o_rd_valid,
	input wire logic o_rd_hit,
	// Settings toward the analog chain
	input wire ocr_gain_cfg_t o_gain_cfg,
	input wire logic o_col_offset_valid,
	input wire logic signed [OCR_COMB_W-1:0] o_col_offset,
	input wire logic signed [OCR_GLOBAL_CODE_W-1:0] o_global_offset_value
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);
	wire logic map_hit = i_req.addr == OCR_ADDR_COL_DC
		|| i_req.addr == OCR_ADDR_GAIN_MODE
		|| i_req.addr == OCR_ADDR_GLOBAL || i_req.addr[7:6] == 2'b10;
	sequence s_write(logic [7:0] a);
		i_req.wr && i_req.addr == a;
	endsequence
	// Sign-magnitude setting scaled to converter codes.
	function automatic logic signed [7:0] gcode(logic [7:0] d);
		logic signed [7:0] m;
		m = $signed({1'b0, d[4:0], 2'b00});
		return d[5] ? -m : m;
	endfunction : gcode
	a_read_answer: assert property (
		i_req.rd |=> o_rd_valid && o_rd_hit == $past(map_hit))
		else $error("read answer wrong");
	a_no_stray: assert property (
		!i_req.rd |=> !o_rd_valid) else $error("answer without read");
	a_col_answer: assert property (
		i_col.valid |=> o_col_offset_valid) else $error("no column strobe");
	a_col_quiet: assert property (
		!i_col.valid |=> !o_col_offset_valid && $stable(o_col_offset))
		else $error("column offset moved without strobe");
	a_global_late: assert property (
		s_write(OCR_ADDR_GLOBAL) |->
		##2 o_global_offset_value == gcode($past(i_req.data, 2)))
		else $error("global offset code wrong");
	a_global_grid: assert property (
		o_global_offset_value[1:0] == 2'b00
		&& o_global_offset_value >= -124 && o_global_offset_value <= 124)
		else $error("global offset off grid");
	a_wb_mode: assert property (
		s_write(OCR_ADDR_GAIN_MODE) |->
		##2 o_gain_cfg.wb_linear == $past(i_req.data[2], 2))
		else $error("white balance mode wrong");
	a_linear2_solo: assert property (
		o_gain_cfg.exp_mode == OCR_EGM_LINEAR2 |-> !o_gain_cfg.gain_b_used)
		else $error("second gain used in linear2");
endmodule : ocr_offset_regs_asserts
bind ocr_offset_regs ocr_offset_regs_asserts ocr_offset_regs_asserts_inst (
	.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(i_req), .i_col(i_col),
	.o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_rd_hit(o_rd_hit),
	.o_gain_cfg(o_gain_cfg), .o_col_offset_valid(o_col_offset_valid),
	.o_col_offset(o_col_offset),
	.o_global_offset_value(o_global_offset_value));

// file: ocr_host_model.sv
// Serial configuration host model issuing single-byte register accesses.
`timescale 1ns/1ps
module ocr_host_model
	import ocr_pkg::*;
(
	// Clock
	input wire logic i_clk,
	// Register port toward the bank
	output ocr_reg_req_t o_req,
	input wire logic [OCR_DATA_W-1:0] i_rd_data,
	input wire logic i_rd_valid
);
	initial o_req = '0;
	// Data is inverted after a write so stale bytes are never mistaken.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_req = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
		@(negedge i_clk);
		o_req.wr = 1'b0;
		o_req.data = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		int n;
		@(negedge i_clk);
		o_req = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
		@(negedge i_clk);
		o_req.rd = 1'b0;
		for (n = 0; i_rd_valid !== 1'b1 && n < 4; n++)
			@(negedge i_clk);
		d = i_rd_data;
	endtask : rd
endmodule : ocr_host_model

// file: ocr_offset_regs_tb_top.sv
// Self-checking bench for the offset register bank.
`timescale 1ns/1ps
`define OCR_CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
	errors++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module ocr_offset_regs_tb_top
	import ocr_pkg::*;
;
	logic i_clk, i_reset_n, rval, rhit, cval;
	ocr_reg_req_t req;
	ocr_col_t col;
	ocr_gain_cfg_t gcfg;
	logic [7:0] rdat, d;
	logic signed [6:0] cofs;
	logic signed [7:0] gofs;
	int errors, n_compared;
	ocr_offset_regs ocr_offset_regs_inst (.i_clk(i_clk),
		.i_reset_n(i_reset_n), .i_req(req), .o_rd_data(rdat),
		.o_rd_valid(rval), .o_rd_hit(rhit), .i_col(col), .o_gain_cfg(gcfg),
		.o_col_offset_valid(cval), .o_col_offset(cofs),
		.o_global_offset_value(gofs));
	ocr_host_model ocr_host_model_inst (.i_clk(i_clk), .o_req(req),
		.i_rd_data(rdat), .i_rd_valid(rval));
	function automatic int sm(logic [5:0] f);
		return f[5] ? -int'(f[4:0]) : int'(f[4:0]);
	endfunction : sm
	function automatic logic [5:0] tv(int k);
		return 6'((k * 7 + 3) % 64);
	endfunction : tv
	task automatic t_table;
		for (int k = 0; k < 64; k++)
			ocr_host_model_inst.wr(OCR_ADDR_COL_BASE + 8'(k), {2'b11, tv(k)});
		for (int k = 0; k < 64; k++) begin
			ocr_host_model_inst.rd(OCR_ADDR_COL_BASE + 8'(k), d);
			`OCR_CHK("col reg", {2'b00, tv(k)}, d)
			`OCR_CHK("hit", 1'b1, rhit)
			`OCR_CHK("rvalid", 1'b1, rval)
		end
		ocr_host_model_inst.rd(8'hC0, d);
		`OCR_CHK("unmapped", 1'b0, rhit)
	endtask : t_table
	task automatic t_cols;
		// Column DC is set to -5 and the table holds tv(k), so the bench predicts the output offset directly.
		ocr_host_model_inst.wr(OCR_ADDR_COL_DC, 8'hE5);
		for (int k = 0; k <= 130; k++) begin
			@(negedge i_clk);
			if (k > 0) begin
				`OCR_CHK("col vld", 1'b1, cval)
				`OCR_CHK("col ofs", sm(6'h25) + sm(tv((k - 1) % 64)), cofs)
			end
			col = '{valid: 1'b1, index: 11'(k)};
		end
		@(negedge i_clk);
		col.valid = 1'b0;
	endtask : t_cols
	task automatic t_global;
		logic [7:0] gv [4] = '{8'h17, 8'h3F, 8'h1F, 8'hE0};
		int gx [4] = '{92, -124, 124, 0};
		foreach (gv[i]) begin
			ocr_host_model_inst.wr(OCR_ADDR_GLOBAL, gv[i]);
			@(negedge i_clk);
			`OCR_CHK("global", gx[i], gofs)
		end
	endtask : t_global
	task automatic t_gain;
		for (int m = 0; m < 8; m++) begin
			ocr_host_model_inst.wr(OCR_ADDR_GAIN_MODE, 8'(m) | 8'hF8);
			@(negedge i_clk);
			`OCR_CHK("wb", m[2], gcfg.wb_linear)
			`OCR_CHK("egm", (m % 4 == 3) ? 0 : m % 4, gcfg.exp_mode)
			`OCR_CHK("gb", m % 4 != 2, gcfg.gain_b_used)
		end
	endtask : t_gain
	task automatic tally_and_finish;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	initial begin
		i_reset_n = 1'b0;
		col = '0;
		errors = 0;
		n_compared = 0;
		repeat (5) @(negedge i_clk);
		i_reset_n = 1'b1;
		ocr_host_model_inst.rd(OCR_ADDR_COL_DC, d);
		`OCR_CHK("dc reset", 8'h00, d)
		t_table();
		t_cols();
		t_global();
		t_gain();
		tally_and_finish();
	end
	initial begin
		#20000;
		errors++;
		tally_and_finish();
	end
endmodule : ocr_offset_regs_tb_top
